// file: core/lsm_pkg.sv
// Constants and types for the load/store multiple and exclusive unit.
// Assumes a 16-entry register file with stack pointer, link and PC on top.
package lsm_pkg;

  localparam int          XLEN       = 32;
  localparam int          NREG       = 16;
  localparam logic [3:0]  SP_IDX     = 4'hd;
  localparam logic [3:0]  LR_IDX     = 4'he;
  localparam logic [3:0]  PC_IDX     = 4'hf;
  localparam logic [31:0] WORD_STEP  = 32'h4;
  localparam logic [12:0] PCREL_MAX  = 13'h0fff;
  localparam logic [12:0] DUAL_MAX   = 13'h03fc;
  localparam logic [31:0] STAT_OK    = 32'h0;
  localparam logic [31:0] STAT_FAIL  = 32'h1;
  localparam logic [15:0] LIST_EMPTY = 16'h0;

  typedef enum logic [4:0] {
    OP_LD_MULTI     = 5'h00,  // load_multiple, no variant given
    OP_LD_INCR      = 5'h01,
    OP_LD_DECR      = 5'h02,
    OP_LD_FULL_DESC = 5'h03,  // pop_full_descending_alias
    OP_LD_EMPTY_ASC = 5'h04,  // pop_empty_ascending_alias
    OP_ST_MULTI     = 5'h05,  // store_multiple, no variant given
    OP_ST_INCR      = 5'h06,
    OP_ST_DECR      = 5'h07,
    OP_ST_EMPTY_ASC = 5'h08,  // push_empty_ascending_alias
    OP_ST_FULL_DESC = 5'h09,  // push_full_descending_alias
    OP_PUSH         = 5'h0a,
    OP_POP          = 5'h0b,
    OP_LD_PCREL     = 5'h0c,  // load_register, pc-relative
    OP_LDRD_PC      = 5'h0d,  // two-word load, pc-relative
    OP_XLOAD        = 5'h0e,  // exclusive_load
    OP_XSTORE       = 5'h0f,  // exclusive_store
    OP_XCLEAR       = 5'h10   // clear_exclusive
  } op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } size_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SEL   = 3'b001,
    S_ISSUE = 3'b010,
    S_WAIT  = 3'b011,
    S_DONE  = 3'b100
  } state_t;

endpackage

// file: core/load_extend.sv
// Widens a loaded byte or halfword to a full register.
// Assumes memory returns the addressed item in the low bits.
`timescale 1ns/100ps
module load_extend
  import lsm_pkg::*;
(
  // Loaded item
  input  wire logic [31:0] data_i,
  input  wire size_t       size_i,
  input  wire logic        sign_i,
  // Register value
  output logic      [31:0] data_o
);

  logic [23:0] byte_fill;
  logic [15:0] half_fill;

  assign byte_fill = sign_i ? {24{data_i[7]}} : 24'h0;
  assign half_fill = sign_i ? {16{data_i[15]}} : 16'h0;
  assign data_o = (size_i == SZ_BYTE) ? {byte_fill, data_i[7:0]} :
                  (size_i == SZ_HALF) ? {half_fill, data_i[15:0]} :
                  data_i;

endmodule // load_extend

// file: core/excl_monitor.sv
// Local exclusive monitor: one tagged address and size.
// Assumes other agents report their writes on the snoop port.
`timescale 1ns/100ps
module excl_monitor
  import lsm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Tag from exclusive load
  input  wire logic        set_i,
  input  wire logic [31:0] set_addr_i,
  input  wire size_t       set_size_i,
  // Clears
  input  wire logic        clear_i,
  input  wire logic        snoop_i,
  input  wire logic [31:0] snoop_addr_i,
  // Check for exclusive store
  input  wire logic [31:0] chk_addr_i,
  input  wire size_t       chk_size_i,
  output logic             pass_o,
  output logic             valid_o
);

  logic        valid_ff;
  logic [31:0] addr_ff;
  size_t       size_ff;
  logic        snoop_hit;

  // Word granule: any foreign access in the word breaks the reservation
  assign snoop_hit = snoop_i && (snoop_addr_i[31:2] == addr_ff[31:2]);
  assign pass_o  = valid_ff && (chk_addr_i == addr_ff)
                   && (chk_size_i == size_ff);
  assign valid_o = valid_ff;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_ff <= 1'b0;
      addr_ff  <= 32'h0;
      size_ff  <= SZ_WORD;
    end else if (set_i) begin
      // A new tag wins over a clear in the same cycle
      valid_ff <= 1'b1;
      addr_ff  <= set_addr_i;
      size_ff  <= set_size_i;
    end else if (clear_i || snoop_hit) begin
      valid_ff <= 1'b0;
    end
  end

endmodule // excl_monitor

// file: core/lsm_unit.sv
// Executes pc-relative loads, multiple transfers, push/pop and exclusives.
// Assumes the core holds off start_i while busy_o, reads registers the
// cycle after rf_raddr_o changes, and memory answers with a one-cycle ack.
//
// Summary of operation
// - Byte and halfword loads are zero-extended to 32 bits, or sign-extended if pc-relative with sign_i set.
// - Pc-relative load address is pc plus signed label offset.
// - Offset limits 4095 for single loads, 1020 for two-word loads.
// - A word load into pc branches to the value with bit 0 cleared.
// - A multiple transfer without variant runs as increment-after.
// - Increment-after walks up in 4-byte steps, lowest register first.
// - Decrement-before walks down in 4-byte steps, highest register first; here the first transfer is at the base itself, not base minus 4.
// - Writeback puts the final transfer address into the base register.
// - Stack alias forms behave exactly as their plain equivalents.
// - Push is decrement-before store, pop increment-after load, on sp; here push makes its first store at the base itself, not 4 below it.
// - Multiple load or pop into pc branches with bit 0 cleared.
// - Exclusive loads and stores in word, byte and halfword sizes.
// - Exclusive address is base plus optional offset.
// - Exclusive store writes status 0 when stored, 1 when suppressed.
// - Exclusive store succeeds only if the reservation is intact.
// - No operation here writes the condition flags.
// - Clear-exclusive makes the next exclusive store fail.
`timescale 1ns/100ps
module lsm_unit
  import lsm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Request
  input  wire logic        start_i,
  input  wire op_t         op_i,
  input  wire size_t       size_i,
  input  wire logic        sign_i,
  input  wire logic [31:0] pc_i,
  input  wire logic [31:0] base_i,
  input  wire logic [3:0]  base_idx_i,
  input  wire logic [12:0] offset_i,
  input  wire logic [15:0] reglist_i,
  input  wire logic        wback_i,
  input  wire logic [3:0]  xfer_reg_i,
  input  wire logic [3:0]  second_reg_i,
  input  wire logic [3:0]  rd_i,
  // Status
  output logic             busy_o,
  output logic             done_o,
  output logic             err_o,
  // Register read
  output logic      [3:0]  rf_raddr_o,
  input  wire logic [31:0] rf_rdata_i,
  // Register write
  output logic             rf_we_o,
  output logic      [3:0]  rf_waddr_o,
  output logic      [31:0] rf_wdata_o,
  // Branch
  output logic             branch_o,
  output logic      [31:0] branch_target_o,
  // Flags
  output logic             flags_we_o,
  // Memory
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_addr_o,
  output size_t            mem_size_o,
  output logic      [31:0] mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  // Foreign accesses
  input  wire logic        snoop_i,
  input  wire logic [31:0] snoop_addr_i
);

  state_t      state_ff;
  logic [15:0] list_ff;
  logic [3:0]  cur_ff, sec_ff, wb_idx_ff, rd_ff;
  logic [31:0] addr_ff, last_ff;
  logic        multi_ff, asc_ff, load_ff, wb_ff, sec_pend_ff;
  logic        xstore_ff, xload_ff, pass_ff, sgn_ff;
  size_t       size_ff;

  logic        is_incr, is_decr, is_multi, is_ld_m, is_stack, is_pcrel;
  logic        accept, range_bad, excl_pass, excl_valid, mon_set, mon_clr;
  logic [12:0] off_abs;
  logic [31:0] off_ext, pcrel_addr, ex_addr, ext_data;
  logic [15:0] list_left;
  logic [3:0]  sel_idx;

  // Alias decode: plain and stack-named forms share one datapath
  assign is_incr = (op_i == OP_LD_MULTI) || (op_i == OP_LD_INCR) ||
                   (op_i == OP_LD_FULL_DESC) ||
                   (op_i == OP_ST_MULTI) || (op_i == OP_ST_INCR) ||
                   (op_i == OP_ST_EMPTY_ASC) || (op_i == OP_POP);
  assign is_decr = (op_i == OP_LD_DECR) ||
                   (op_i == OP_LD_EMPTY_ASC) || (op_i == OP_ST_DECR) ||
                   (op_i == OP_ST_FULL_DESC) || (op_i == OP_PUSH);
  assign is_multi = is_incr || is_decr;
  assign is_ld_m  = (op_i == OP_LD_MULTI) || (op_i == OP_LD_INCR) ||
                    (op_i == OP_LD_DECR) || (op_i == OP_LD_FULL_DESC) ||
                    (op_i == OP_LD_EMPTY_ASC) || (op_i == OP_POP);
  assign is_stack = (op_i == OP_PUSH) || (op_i == OP_POP);
  assign is_pcrel = (op_i == OP_LD_PCREL) || (op_i == OP_LDRD_PC);

  assign off_ext    = {{19{offset_i[12]}}, offset_i};
  assign off_abs    = offset_i[12] ? (13'h0 - offset_i) : offset_i;
  // An offset of -4096 folds to 13'h1000, which still compares as too big
  assign range_bad  = ((op_i == OP_LD_PCREL) && (off_abs > PCREL_MAX)) ||
                      ((op_i == OP_LDRD_PC) && (off_abs > DUAL_MAX));
  assign pcrel_addr = pc_i + off_ext;
  assign ex_addr    = base_i + off_ext;
  assign accept     = (state_ff == S_IDLE) && start_i;

  assign list_left  = list_ff & ~(16'h1 << cur_ff);

  // Lowest set register going up, highest going down
  always_comb begin
    sel_idx = 4'h0;
    for (int i = 0; i < NREG; i++) begin
      if (list_ff[i] && (!asc_ff || (sel_idx == 4'h0 && !list_ff[0])))
        sel_idx = 4'(i);
    end
  end

  assign mon_set = (state_ff == S_WAIT) && mem_ack_i && xload_ff;
  assign mon_clr = accept && ((op_i == OP_XSTORE) ||
                              (op_i == OP_XCLEAR));

  excl_monitor u_mon (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .set_i        (mon_set),
    .set_addr_i   (addr_ff),
    .set_size_i   (size_ff),
    .clear_i      (mon_clr),
    .snoop_i      (snoop_i),
    .snoop_addr_i (snoop_addr_i),
    .chk_addr_i   (ex_addr),
    .chk_size_i   (size_i),
    .pass_o       (excl_pass),
    .valid_o      (excl_valid)
  );

  load_extend u_ext (
    .data_i (mem_rdata_i),
    .size_i (size_ff),
    .sign_i (sgn_ff),
    .data_o (ext_data)
  );

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff    <= S_IDLE;
      list_ff     <= LIST_EMPTY;
      {cur_ff, sec_ff, wb_idx_ff, rd_ff} <= 16'h0;
      addr_ff     <= 32'h0;
      last_ff     <= 32'h0;
      {multi_ff, asc_ff, load_ff, wb_ff, sec_pend_ff} <= 5'h0;
      {xstore_ff, xload_ff, pass_ff, sgn_ff} <= 4'h0;
      size_ff     <= SZ_WORD;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      err_o       <= 1'b0;
      rf_raddr_o  <= 4'h0;
      rf_we_o     <= 1'b0;
      rf_waddr_o  <= 4'h0;
      rf_wdata_o  <= 32'h0;
      branch_o    <= 1'b0;
      branch_target_o <= 32'h0;
      flags_we_o  <= 1'b0;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= 32'h0;
      mem_size_o  <= SZ_WORD;
      mem_wdata_o <= 32'h0;
    end else begin
      rf_we_o    <= 1'b0;
      branch_o   <= 1'b0;
      done_o     <= 1'b0;
      err_o      <= 1'b0;
      flags_we_o <= 1'b0;
      case (state_ff)
        S_IDLE: if (start_i) begin
          multi_ff    <= is_multi;
          asc_ff      <= is_incr;
          load_ff     <= is_ld_m || is_pcrel || (op_i == OP_XLOAD);
          xload_ff    <= (op_i == OP_XLOAD);
          xstore_ff   <= (op_i == OP_XSTORE);
          pass_ff     <= excl_pass;
          sec_pend_ff <= (op_i == OP_LDRD_PC);
          cur_ff      <= xfer_reg_i;
          sec_ff      <= second_reg_i;
          rd_ff       <= rd_i;
          rf_raddr_o  <= xfer_reg_i;
          list_ff     <= reglist_i;
          wb_ff       <= wback_i || is_stack;
          wb_idx_ff   <= is_stack ? SP_IDX : base_idx_i;
          sgn_ff      <= sign_i && is_pcrel;
          size_ff     <= (is_multi || op_i == OP_LDRD_PC) ? SZ_WORD : size_i;
          addr_ff     <= is_pcrel ? pcrel_addr :
                         (is_multi ? base_i : ex_addr);
          busy_o      <= 1'b1;
          if (range_bad) begin
            err_o  <= 1'b1;
            busy_o <= 1'b0;
          end else if (is_multi) begin
            state_ff <= S_SEL;
          end else if (op_i == OP_XCLEAR) begin
            state_ff <= S_DONE;
          end else if (op_i == OP_XSTORE) begin
            state_ff <= excl_pass ? S_ISSUE : S_DONE;
          end else begin
            state_ff <= S_ISSUE;
          end
        end
        S_SEL: begin
          if (list_ff == LIST_EMPTY) begin
            state_ff <= S_DONE;
          end else begin
            cur_ff     <= sel_idx;
            rf_raddr_o <= sel_idx;
            state_ff   <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          mem_req_o   <= 1'b1;
          mem_we_o    <= !load_ff;
          mem_addr_o  <= addr_ff;
          mem_size_o  <= size_ff;
          mem_wdata_o <= rf_rdata_i;
          state_ff    <= S_WAIT;
        end
        S_WAIT: if (mem_ack_i) begin
          mem_req_o <= 1'b0;
          last_ff   <= addr_ff;
          if (load_ff && cur_ff == PC_IDX) begin
            branch_o        <= 1'b1;
            branch_target_o <= {mem_rdata_i[31:1], 1'b0};
            err_o           <= !mem_rdata_i[0];
          end else if (load_ff) begin
            rf_we_o    <= 1'b1;
            rf_waddr_o <= cur_ff;
            rf_wdata_o <= ext_data;
          end
          if (multi_ff) begin
            list_ff  <= list_left;
            addr_ff  <= asc_ff ? addr_ff + WORD_STEP
                               : addr_ff - WORD_STEP;
            state_ff <= S_SEL;
          end else if (sec_pend_ff) begin
            sec_pend_ff <= 1'b0;
            cur_ff      <= sec_ff;
            addr_ff     <= addr_ff + WORD_STEP;
            state_ff    <= S_ISSUE;
          end else begin
            state_ff <= S_DONE;
          end
        end
        S_DONE: begin
          if (multi_ff && wb_ff) begin
            rf_we_o    <= 1'b1;
            rf_waddr_o <= wb_idx_ff;
            rf_wdata_o <= last_ff;
          end else if (xstore_ff) begin
            rf_we_o    <= 1'b1;
            rf_waddr_o <= rd_ff;
            rf_wdata_o <= pass_ff ? STAT_OK : STAT_FAIL;
          end
          done_o   <= 1'b1;
          busy_o   <= 1'b0;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  a_flags_untouched: assert property (
    @(posedge clk_i) disable iff (!resetn_i) !flags_we_o)
    else $error("flag write from load/store unit");

  a_branch_even: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    branch_o |-> (branch_target_o[0] == 1'b0) && !rf_we_o)
    else $error("branch target keeps bit 0");

  a_pcrel_address: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (accept && is_pcrel && !range_bad)
      |-> ##2 mem_req_o && mem_addr_o == $past(pcrel_addr, 2))
    else $error("pc-relative address wrong");

  a_range_refused: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (accept && range_bad) |=> err_o && state_ff == S_IDLE && !mem_req_o)
    else $error("out-of-range offset not refused");

  a_ascend_step: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (state_ff == S_WAIT && mem_ack_i && multi_ff && asc_ff
      && list_left != LIST_EMPTY)
      |-> ##3 mem_addr_o == $past(mem_addr_o, 3) + WORD_STEP)
    else $error("ascending step not +4");

  a_descend_step: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (state_ff == S_WAIT && mem_ack_i && multi_ff && !asc_ff
      && list_left != LIST_EMPTY)
      |-> ##3 mem_addr_o == $past(mem_addr_o, 3) - WORD_STEP)
    else $error("descending step not -4");

  a_xstore_fail: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (accept && op_i == OP_XSTORE && !excl_pass)
      |-> ##1 !mem_req_o ##1 rf_we_o && rf_wdata_o == STAT_FAIL
          && !mem_req_o)
    else $error("failed exclusive store not suppressed");

  a_monitor_cleared: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    mon_clr |=> !excl_valid)
    else $error("monitor survives exclusive store or clear");

endmodule // lsm_unit

// file: dv/mem_model.sv
// Behavioural memory beside the load/store unit: 256 words, answered
// after lat_i idle cycles. Assumes the unit holds its request until ack.
`timescale 1ns/100ps
module mem_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Request from the unit
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [1:0]  lat_i,
  // Answer
  output logic             ack_o,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem [256];
  logic [31:0] log_addr [$];
  logic [31:0] log_data [$];
  logic [1:0]  cnt_ff;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {16'hd00d, 8'(i), 8'h01};
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
      cnt_ff <= 2'h0;
      rdata_o <= 32'h0;
    end else if (req_i && !ack_o && cnt_ff == lat_i) begin
      ack_o <= 1'b1;
      cnt_ff <= 2'h0;
      log_addr.push_back(addr_i);
      log_data.push_back(we_i ? wdata_i : mem[addr_i[9:2]]);
      rdata_o <= mem[addr_i[9:2]];
      if (we_i) begin
        mem[addr_i[9:2]] <= wdata_i;
      end
    end else begin
      // Data is not held after ack: a changing pattern exposes stale reads
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        cnt_ff <= cnt_ff + 2'h1;
      end
    end
  end
endmodule // mem_model

// file: dv/testbench.sv
// Self-checking bench for the load/store multiple and exclusive unit.
// Assumes mem_model serves memory and a fixed pattern serves reg reads.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import lsm_pkg::*;
  logic        clk_i, resetn_i, start_i, sign_i, wback_i, snoop_i;
  logic        busy_o, done_o, err_o, rf_we_o, branch_o, flags_we_o;
  logic        mem_req_o, mem_we_o, mem_ack_i, got_err;
  op_t         op_i;
  size_t       size_i, mem_size_o;
  logic [31:0] pc_i, base_i, rf_rdata_i, rf_wdata_o, branch_target_o;
  logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, snoop_addr_i;
  logic [12:0] offset_i;
  logic [15:0] reglist_i;
  logic [3:0]  base_idx_i, xfer_reg_i, second_reg_i, rd_i;
  logic [3:0]  rf_raddr_o, rf_waddr_o;
  logic [1:0]  lat;
  logic [3:0]  rf_a [$];
  logic [31:0] rf_d [$];
  logic [31:0] br_q [$];
  size_t       sz_q [$];
  int          n_mismatch, checks_done, cyc;

  assign rf_rdata_i = {28'h5a5a5a0, rf_raddr_o};

  lsm_unit dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i), .op_i(op_i),
    .size_i(size_i), .sign_i(sign_i), .pc_i(pc_i), .base_i(base_i),
    .base_idx_i(base_idx_i), .offset_i(offset_i), .reglist_i(reglist_i),
    .wback_i(wback_i), .xfer_reg_i(xfer_reg_i),
    .second_reg_i(second_reg_i), .rd_i(rd_i),
    .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
    .rf_raddr_o(rf_raddr_o), .rf_rdata_i(rf_rdata_i), .rf_we_o(rf_we_o),
    .rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o), .branch_o(branch_o),
    .branch_target_o(branch_target_o), .flags_we_o(flags_we_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_size_o(mem_size_o), .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .snoop_i(snoop_i),
    .snoop_addr_i(snoop_addr_i));

  mem_model mem_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .req_i(mem_req_o),
    .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .lat_i(lat), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  function automatic logic [31:0] rd(input logic [3:0] r);
    return {28'h5a5a5a0, r};
  endfunction
  function automatic logic [31:0] w(input logic [31:0] a);
    return {16'hd00d, a[9:2], 8'h01};
  endfunction

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (rf_we_o === 1'b1) begin
      rf_a.push_back(rf_waddr_o);
      rf_d.push_back(rf_wdata_o);
    end
    if (branch_o === 1'b1) br_q.push_back(branch_target_o);
    if (mem_ack_i === 1'b1) sz_q.push_back(mem_size_o);
    if (resetn_i) `CHK(flags_we_o, 1'b0)
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Clears the logs, launches one request, waits for done or refusal
  task automatic go(input op_t op);
    rf_a.delete();
    rf_d.delete();
    br_q.delete();
    sz_q.delete();
    mem_u.log_addr.delete();
    mem_u.log_data.delete();
    @(posedge clk_i);
    op_i <= op;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk_i);
      if (i == 0) `CHK(busy_o, !err_o)
      if (done_o === 1'b1 || err_o === 1'b1) break;
    end
    got_err = err_o;
    `CHK(done_o | err_o, 1'b1)
    if (done_o === 1'b1) `CHK(busy_o, 1'b0)
    @(posedge clk_i);
    #1;
  endtask

  task automatic t_pc();
    logic [31:0] v [5];
    logic [12:0] off [4];
    logic [31:0] ea [4];
    v = '{32'h81, 32'hffffff81, 32'h8081, 32'hffff8081, 32'h12348081};
    off = '{13'h0fff, 13'h1000, 13'h1c04, 13'h0400};
    ea = '{32'h1fff, 32'h0, 32'hc04, 32'h0};
    pc_i <= 32'h100;
    xfer_reg_i <= 4'hf;
    go(OP_LD_PCREL);
    `CHK(br_q[0], w(32'h100) & ~32'h1)
    `CHK(got_err | rf_a.size() != 0, 1'b0)
    mem_u.mem[8'h40] = 32'h2468;
    go(OP_LD_PCREL);
    `CHK(got_err, 1'b1)
    mem_u.mem[8'h42] = 32'h12348081;
    for (int k = 0; k < 5; k++) begin
      size_i <= size_t'(k / 2);
      sign_i <= 1'(k % 2);
      pc_i <= (k % 2) ? 32'h110 : 32'h100;
      offset_i <= (k % 2) ? 13'h1ff8 : 13'h0008;
      xfer_reg_i <= 4'h3;
      go(OP_LD_PCREL);
      `CHK(mem_u.log_addr[0], 32'h108)
      `CHK(rf_d[0], v[k])
      `CHK(sz_q[0], size_t'(k / 2))
    end
    for (int k = 0; k < 4; k++) begin
      size_i <= SZ_BYTE;
      sign_i <= 1'b0;
      pc_i <= 32'h1000;
      offset_i <= off[k];
      second_reg_i <= 4'h5;
      go(k < 2 ? OP_LD_PCREL : OP_LDRD_PC);
      `CHK(got_err, 1'(k % 2))
      `CHK(mem_u.log_addr.size(), (k % 2) ? 0 : k / 2 + 1)
      if (k % 2 == 0) `CHK(mem_u.log_addr[0], ea[k])
      if (k == 2) begin
        `CHK(mem_u.log_addr[1], 32'hc08)
        `CHK(rf_a[1], 4'h5)
        `CHK(rf_d[1], w(32'hc08))
      end
    end
  endtask

  task automatic t_multi(input bit st);
    op_t         ops [5];
    logic [3:0]  r [3];
    logic [31:0] a;
    bit          dn;
    r = '{4'h1, 4'h2, 4'h9};
    if (st) ops = '{OP_ST_MULTI, OP_ST_INCR, OP_ST_EMPTY_ASC, OP_ST_DECR,
                    OP_ST_FULL_DESC};
    else ops = '{OP_LD_MULTI, OP_LD_INCR, OP_LD_FULL_DESC, OP_LD_DECR,
                 OP_LD_EMPTY_ASC};
    for (int k = 0; k < 5; k++) begin
      dn = (k > 2);
      base_i <= st ? 32'h300 : 32'h200;
      reglist_i <= 16'h0206;
      base_idx_i <= 4'h7;
      wback_i <= !st;
      lat <= st ? 2'h2 : 2'h0;
      go(ops[k]);
      `CHK(mem_u.log_addr.size(), 3)
      for (int j = 0; j < 3; j++) begin
        a = dn ? base_i - 4 * j : base_i + 4 * j;
        `CHK(mem_u.log_addr[j], a)
        `CHK(sz_q[j], SZ_WORD)
        if (st) `CHK(mem_u.log_data[j], rd(r[dn ? 2 - j : j]))
        else `CHK(rf_d[j], w(a))
        if (!st) `CHK(rf_a[j], r[dn ? 2 - j : j])
      end
      if (st) `CHK(rf_a.size(), 0)
      else `CHK(rf_d[3], dn ? base_i - 8 : base_i + 8)
    end
    wback_i <= 1'b0;
  endtask

  task automatic t_stack();
    base_i <= 32'h380;
    reglist_i <= 16'h4001;
    go(OP_PUSH);
    `CHK(mem_u.log_addr[0], 32'h380)
    `CHK(mem_u.log_data[0], rd(4'he))
    `CHK(mem_u.log_addr[1], 32'h37c)
    `CHK(mem_u.log_data[1], rd(4'h0))
    `CHK(rf_a[0], SP_IDX)
    `CHK(rf_d[0], 32'h37c)
    base_i <= 32'h200;
    reglist_i <= 16'h8001;
    go(OP_POP);
    `CHK(rf_d[0], w(32'h200))
    `CHK(br_q[0], w(32'h204) & ~32'h1)
    `CHK(got_err, 1'b0)
    `CHK(rf_a[1], SP_IDX)
    `CHK(rf_d[1], 32'h204)
  endtask

  task automatic ex(input op_t op, input logic [31:0] b, input size_t sz);
    base_i <= b;
    size_i <= sz;
    offset_i <= (sz == SZ_WORD) ? 13'h0004 : 13'h0000;
    xfer_reg_i <= 4'h6;
    rd_i <= 4'h8;
    go(op);
  endtask

  task automatic t_excl();
    logic [31:0] a;
    logic [31:0] m;
    for (int k = 0; k < 3; k++) begin
      a = 32'h240 + 16 * k + ((k == 2) ? 4 : 0);
      m = (k == 0) ? 32'hff : (k == 1) ? 32'hffff : 32'hffffffff;
      ex(OP_XLOAD, 32'h240 + 16 * k, size_t'(k));
      `CHK(mem_u.log_addr[0], a)
      `CHK(sz_q[0], size_t'(k))
      `CHK(rf_d[0], w(a) & m)
      ex(OP_XSTORE, 32'h240 + 16 * k, size_t'(k));
      `CHK(mem_u.log_data[0] & m, rd(4'h6) & m)
      `CHK(rf_a[0], 4'h8)
      `CHK(rf_d[0], STAT_OK)
      ex(OP_XSTORE, 32'h240 + 16 * k, size_t'(k));
      `CHK(rf_d[0], STAT_FAIL)
      `CHK(mem_u.log_addr.size(), 0)
    end
    ex(OP_XLOAD, 32'h260, SZ_WORD);
    go(OP_XCLEAR);
    ex(OP_XSTORE, 32'h260, SZ_WORD);
    `CHK(rf_d[0], STAT_FAIL)
    for (int j = 0; j < 2; j++) begin
      ex(OP_XLOAD, 32'h260, SZ_WORD);
      @(posedge clk_i);
      snoop_addr_i <= 32'h264 + 8 * j;
      snoop_i <= 1'b1;
      @(posedge clk_i);
      snoop_i <= 1'b0;
      ex(OP_XSTORE, 32'h260, SZ_WORD);
      `CHK(rf_d[0], j ? STAT_OK : STAT_FAIL)
    end
  endtask

  initial begin
    resetn_i = 1'b0;
    start_i = 1'b0;
    sign_i = 1'b0;
    wback_i = 1'b0;
    snoop_i = 1'b0;
    op_i = OP_LD_MULTI;
    size_i = SZ_WORD;
    lat = 2'h0;
    pc_i = 32'h0;
    base_i = 32'h0;
    snoop_addr_i = 32'h0;
    offset_i = 13'h0;
    reglist_i = 16'h0;
    base_idx_i = 4'h0;
    xfer_reg_i = 4'h0;
    second_reg_i = 4'h0;
    rd_i = 4'h0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_pc();
    t_multi(1'b0);
    t_multi(1'b1);
    t_stack();
    t_excl();
    end_of_test();
  end
endmodule // testbench
